// ---- core/gpio_port_pkg.sv ----
// Constants and carrier types for the four-bank general purpose I/O port.
// Assumes offsets are relative to the runtime register block base, decoded outside.
package gpio_port_pkg;

  localparam int NUM_PINS = 22;
  localparam int PIN_IDX_W = 5;

  // Data banks C, D, E and F at consecutive offsets.
  localparam logic [7:0] DATA_C_OFS = 8'h4D;
  localparam logic [7:0] DATA_D_OFS = 8'h4E;
  localparam logic [7:0] DATA_E_OFS = 8'h4F;
  localparam logic [7:0] DATA_F_OFS = 8'h50;
  localparam logic [7:0] BANK_COUNT = 8'h04;

  // One configuration register per pin, pin index added to the base.
  localparam logic [7:0] CFG_BASE_OFS = 8'h30;
  localparam logic [7:0] CFG_COUNT = 8'h16;

  // Wake and interrupt registers, one per bank except the single global wake register.
  localparam logic [7:0] WAKE_STS_OFS = 8'h60;
  localparam logic [7:0] WAKE_EN_OFS = 8'h64;
  localparam logic [7:0] GLOBAL_WAKE_OFS = 8'h68;
  localparam logic [7:0] SMI_STS_OFS = 8'h69;
  localparam logic [7:0] SMI_CLR_OFS = 8'h6D;
  localparam logic [7:0] SMI_EN_OFS = 8'h71;

  // Configuration field values and reset state.
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam logic [7:0] CFG_WR_MASK = 8'h8F;
  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic [1:0] FUNC_ALT1 = 2'h1;
  localparam logic [1:0] FUNC_ALT2 = 2'h2;
  localparam logic [1:0] FUNC_ALT3 = 2'h3;

  // Pins whose either-edge function sits at alternate 2 or alternate 3.
  localparam logic [21:0] EITHER_EDGE_INTERRUPT_ALT2_PINS = 22'h300200;
  localparam logic [21:0] EITHER_EDGE_INTERRUPT_ALT3_PINS = 22'h000800;
  // Pin carrying the device-disable register control as alternate 1.
  localparam logic [21:0] DEVICE_DISABLE_REG_CONTROL_PINS = 22'h000800;

  localparam logic [21:0] PIN_ZERO = 22'h000000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;

  typedef struct packed {
    logic openDrain;
    logic [2:0] rsvd;
    logic [1:0] func;
    logic invert;
    logic dirIn;
  } pinCfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } regReq_t;

endpackage

// ---- core/gpio_port_with_wake_status.sv ----
// General purpose I/O banks C to F with per-pin configuration, wake status and SMI status.
// Assumes bus address is the offset inside the runtime block and pins are synchronous.
`timescale 1ns/1ns
`default_nettype none

module gpio_port_with_wake_status
  import gpio_port_pkg::*;
(
  input wire logic core_clk, // System clock, 20 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  input wire regReq_t busReq, // Register request: address, data, strobes.
  output logic [7:0] rdData, // Read data, valid the cycle after the read.
  input wire logic [NUM_PINS-1:0] pinIn, // Level seen on each pin.
  output logic [NUM_PINS-1:0] pinOut, // Level driven on each pin.
  output logic [NUM_PINS-1:0] pinOe, // High while the pin is driven.
  input wire logic [NUM_PINS-1:0] altOut, // Alternate function output value.
  input wire logic [NUM_PINS-1:0] altOe, // Alternate function drive request.
  output logic [NUM_PINS-1:0] altIn, // Pin value towards alternate functions.
  output logic pme, // Power management event, level.
  output logic smiIrq // Interrupt, high while an enabled SMI status is set.
);

  // Extract one bank from a pin vector; unused bank bits come back as zero.
  function automatic logic [7:0] getBank(input logic [21:0] v, input logic [1:0] b);
    logic [7:0] r;
    r = BYTE_ZERO;
    case (b)
      2'h0: r = v[7:0];
      2'h1: r = {4'h0, v[11:8]};
      2'h2: r = v[19:12];
      default: r = {6'h00, v[21:20]};
    endcase
    return r;
  endfunction

  // Place a bank byte at its pin positions; reserved bank bits are dropped.
  function automatic logic [21:0] spread(input logic [7:0] v, input logic [1:0] b);
    logic [21:0] r;
    r = PIN_ZERO;
    case (b)
      2'h0: r = {14'h0000, v};
      2'h1: r = {10'h000, v[3:0], 8'h00};
      2'h2: r = {2'h0, v, 12'h000};
      default: r = {v[1:0], 20'h00000};
    endcase
    return r;
  endfunction

  // Replace one bank of a pin vector with a written byte.
  function automatic logic [21:0] merge(input logic [21:0] old, input logic [7:0] v,
                                        input logic [1:0] b);
    return (old & ~spread(BYTE_ONES, b)) | spread(v, b);
  endfunction

  // True when an offset falls inside a four-register run that starts at base.
  function automatic logic inRun(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] rel;
    rel = a - base;
    return rel < BANK_COUNT;
  endfunction

  // The bank maps in the functions above are written out for 22 pins in four banks,
  // so any other package sizing is refused at elaboration.
  if (NUM_PINS != 22) begin : gPinCountCheck
    $error("gpio port: bank map needs exactly 22 pins");
  end
  if (CFG_COUNT != 8'(NUM_PINS)) begin : gCfgCountCheck
    $error("gpio port: one configuration register per pin is required");
  end
  if ((1 << PIN_IDX_W) < NUM_PINS) begin : gIdxWidthCheck
    $error("gpio port: pin index too narrow for the pin count");
  end
  if (BANK_COUNT != 8'h04) begin : gBankCountCheck
    $error("gpio port: decode expects four data banks");
  end

  // Stored configuration and pin state.
  pinCfg_t cfgQ [NUM_PINS];
  logic [21:0] dataQ;
  logic [21:0] dataD;
  logic [21:0] pinPrevQ;
  logic edgeArmQ;

  // Event status and enables.
  logic [21:0] wakeStsQ;
  logic [21:0] wakeStsD;
  logic [21:0] wakeEnQ;
  logic globalWakeQ;
  logic [21:0] smiStsQ;
  logic [21:0] smiStsD;
  logic [21:0] smiEnQ;

  // Registered outputs and read data.
  logic [21:0] pinOutQ;
  logic [21:0] pinOeQ;
  logic [21:0] altInQ;
  logic pmeQ;
  logic smiIrqQ;
  logic [7:0] rdDataQ;
  logic [7:0] rdDataD;

  // Address decode.
  wire logic [7:0] addr = busReq.addr;
  wire logic [7:0] wdata = busReq.wdata;

  wire logic [7:0] dataRel = addr - DATA_C_OFS;
  wire logic dataHit = inRun(addr, DATA_C_OFS);
  wire logic [7:0] cfgRel = addr - CFG_BASE_OFS;
  wire logic cfgHit = cfgRel < CFG_COUNT;
  // Out-of-range offsets fold to pin 0 so the array is never indexed past its end.
  wire logic [PIN_IDX_W-1:0] cfgIdx = cfgHit ? cfgRel[PIN_IDX_W-1:0] : '0;

  wire logic [7:0] wStsRel = addr - WAKE_STS_OFS;
  wire logic wStsHit = inRun(addr, WAKE_STS_OFS);
  wire logic [7:0] wEnRel = addr - WAKE_EN_OFS;
  wire logic wEnHit = inRun(addr, WAKE_EN_OFS);
  wire logic gWakeHit = addr == GLOBAL_WAKE_OFS;
  wire logic [7:0] sStsRel = addr - SMI_STS_OFS;
  wire logic sStsHit = inRun(addr, SMI_STS_OFS);
  wire logic [7:0] sClrRel = addr - SMI_CLR_OFS;
  wire logic sClrHit = inRun(addr, SMI_CLR_OFS);
  wire logic [7:0] sEnRel = addr - SMI_EN_OFS;
  wire logic sEnHit = inRun(addr, SMI_EN_OFS);

  wire logic dataWr = busReq.wr && dataHit;
  wire logic dataRd = busReq.rd && dataHit;
  wire logic cfgWr = busReq.wr && cfgHit;
  wire logic wStsWr = busReq.wr && wStsHit;
  wire logic wEnWr = busReq.wr && wEnHit;
  wire logic gWakeWr = busReq.wr && gWakeHit;
  wire logic sClrWr = busReq.wr && sClrHit;
  wire logic sEnWr = busReq.wr && sEnHit;

  wire logic [21:0] dataBankMask = spread(BYTE_ONES, dataRel[1:0]);

  // Per-pin views of configuration and pad logic.
  logic [21:0] dirIn;
  logic [21:0] inv;
  logic [21:0] isGpio;
  logic [21:0] eetiSel;
  logic [21:0] polEff;
  logic [21:0] drvVal;
  logic [21:0] drvReq;
  logic [21:0] oeD;
  logic [21:0] outD;
  logic [21:0] edgeEv;
  logic [21:0] dataView;

  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : gPin
      assign dirIn[i] = cfgQ[i].dirIn;
      assign inv[i] = cfgQ[i].invert;
      assign isGpio[i] = cfgQ[i].func == FUNC_GPIO;
      assign eetiSel[i] = (EITHER_EDGE_INTERRUPT_ALT2_PINS[i] && cfgQ[i].func == FUNC_ALT2) ||
                          (EITHER_EDGE_INTERRUPT_ALT3_PINS[i] && cfgQ[i].func == FUNC_ALT3);
      assign polEff[i] = inv[i] && !eetiSel[i] &&
                         !(DEVICE_DISABLE_REG_CONTROL_PINS[i] && cfgQ[i].func == FUNC_ALT1);
      // Drive data with polarity; alternates drive on request, except the either-edge interrupt function.
      assign drvVal[i] = isGpio[i] ? (dataQ[i] ^ inv[i]) : (altOut[i] ^ polEff[i]);
      assign drvReq[i] = isGpio[i] ? !dirIn[i] : (altOe[i] && !eetiSel[i]);
      // Open-drain only pulls low.
      // A released open-drain pin relies on the board pull-up for its high level.
      assign oeD[i] = drvReq[i] && (cfgQ[i].openDrain ? !drvVal[i] : 1'b1);
      assign outD[i] = cfgQ[i].openDrain ? 1'b0 : drvVal[i];
      // Edge select, either edge when that function is chosen.
      assign edgeEv[i] = edgeArmQ && (eetiSel[i] ? (pinIn[i] ^ pinPrevQ[i]) :
                         (inv[i] ? (pinPrevQ[i] && !pinIn[i]) : (pinIn[i] && !pinPrevQ[i])));
      // Input value seen by the host; outputs show stored bit.
      assign dataView[i] = dirIn[i] ? (pinIn[i] ^ inv[i]) : dataQ[i];
    end
  endgenerate

  // Writes only land on output pins; reads latch inputs.
  // Lanes are the pins of the addressed bank that a write or a read may touch.
  wire logic [21:0] wrLane = dataBankMask & ~dirIn;
  wire logic [21:0] rdLane = dataBankMask & dirIn;
  wire logic [21:0] dataAfterWr = (dataQ & ~wrLane) | (spread(wdata, dataRel[1:0]) & wrLane);
  wire logic [21:0] dataAfterRd = (dataQ & ~rdLane) | (dataView & rdLane);
  assign dataD = dataWr ? dataAfterWr :
                 dataRd ? dataAfterRd :
                 dataQ;

  // Status registers are sticky: only a written one clears a bit.
  // Write one clears; a new edge in the same cycle wins.
  wire logic [21:0] wakeClr = wStsWr ? spread(wdata, wStsRel[1:0]) : PIN_ZERO;
  assign wakeStsD = (wakeStsQ & ~wakeClr) | edgeEv;
  // SMI status per pin, cleared through its clear register.
  wire logic [21:0] smiClr = sClrWr ? spread(wdata, sClrRel[1:0]) : PIN_ZERO;
  assign smiStsD = (smiStsQ & ~smiClr) | edgeEv;

  // Reserved data and status bits read as zero through getBank.
  wire logic [7:0] cfgRdVal = cfgQ[cfgIdx] & CFG_WR_MASK;
  wire logic [7:0] dataRdVal = getBank(dataView, dataRel[1:0]);
  wire logic [7:0] wStsRdVal = getBank(wakeStsQ, wStsRel[1:0]);
  wire logic [7:0] wEnRdVal = getBank(wakeEnQ, wEnRel[1:0]);
  wire logic [7:0] gWakeRdVal = {7'h00, globalWakeQ};
  wire logic [7:0] sStsRdVal = getBank(smiStsQ, sStsRel[1:0]);
  wire logic [7:0] sEnRdVal = getBank(smiEnQ, sEnRel[1:0]);
  assign rdDataD = !busReq.rd ? BYTE_ZERO :
                   dataHit ? dataRdVal :
                   cfgHit ? cfgRdVal :
                   wStsHit ? wStsRdVal :
                   wEnHit ? wEnRdVal :
                   gWakeHit ? gWakeRdVal :
                   sStsHit ? sStsRdVal :
                   sEnHit ? sEnRdVal :
                   BYTE_ZERO;

  // Configuration storage; reset selects the GPIO function.
  // Configuration bits 6:4 are not stored, so they read back as zero.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        cfgQ[p] <= pinCfg_t'(CFG_RESET);
      end
    end else if (cfgWr) begin
      cfgQ[cfgIdx] <= pinCfg_t'(wdata & CFG_WR_MASK);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dataQ <= PIN_ZERO;
    end else begin
      dataQ <= dataD;
    end
  end

  // The previous pin level resets to zero, which would look like a rising edge on every
  // pulled-up pin; edges are therefore ignored until one real sample has been taken.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pinPrevQ <= PIN_ZERO;
      edgeArmQ <= 1'h0;
    end else begin
      pinPrevQ <= pinIn;
      edgeArmQ <= 1'h1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wakeStsQ <= PIN_ZERO;
      smiStsQ <= PIN_ZERO;
    end else begin
      wakeStsQ <= wakeStsD;
      smiStsQ <= smiStsD;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wakeEnQ <= PIN_ZERO;
    end else if (wEnWr) begin
      wakeEnQ <= merge(wakeEnQ, wdata, wEnRel[1:0]);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      globalWakeQ <= 1'h0;
    end else if (gWakeWr) begin
      globalWakeQ <= wdata[0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      smiEnQ <= PIN_ZERO;
    end else if (sEnWr) begin
      smiEnQ <= merge(smiEnQ, wdata, sEnRel[1:0]);
    end
  end

  // Pads and events are registered so every output comes from a flip-flop.
  // The cost is one cycle of latency from pin or register change to the pad.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pinOutQ <= PIN_ZERO;
      pinOeQ <= PIN_ZERO;
      altInQ <= PIN_ZERO;
    end else begin
      pinOutQ <= outD;
      pinOeQ <= oeD;
      altInQ <= pinIn ^ polEff;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pmeQ <= 1'h0;
      smiIrqQ <= 1'h0;
    end else begin
      pmeQ <= globalWakeQ && |(wakeStsQ & wakeEnQ);
      // Enabled SMI status raises the interrupt.
      smiIrqQ <= |(smiStsQ & smiEnQ);
    end
  end

  // Read data falls back to zero when no read is pending, so it stands one cycle.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdDataQ <= BYTE_ZERO;
    end else begin
      rdDataQ <= rdDataD;
    end
  end

  assign rdData = rdDataQ;
  assign pinOut = pinOutQ;
  assign pinOe = pinOeQ;
  assign altIn = altInQ;
  assign pme = pmeQ;
  assign smiIrq = smiIrqQ;

endmodule

`default_nettype wire

// ---- verification/gpio_port_chk.sv ----
// Checker for read timing, reserved bits, pad and event causes at the GPIO port pins.
// Assumes one clock domain and a bus master that never raises both strobes at once.
`timescale 1ns/1ns
`default_nettype none
module gpio_port_chk
  import gpio_port_pkg::*;
(
  input wire logic core_clk, // Clock.
  input wire logic reset, // Reset.
  input wire regReq_t busReq, // Bus.
  input wire logic [7:0] rdData, // Read data.
  input wire logic [NUM_PINS-1:0] pinIn, // Pins.
  input wire logic [NUM_PINS-1:0] pinOut, // Drive.
  input wire logic [NUM_PINS-1:0] pinOe, // Enable.
  input wire logic [NUM_PINS-1:0] altOut, // Alt value.
  input wire logic [NUM_PINS-1:0] altOe, // Alt enable.
  input wire logic [NUM_PINS-1:0] altIn, // Alt input.
  input wire logic pme, // Wake.
  input wire logic smiIrq // Interrupt.
);
  logic [1:0] upCnt_q;
  // The alternate input settles from its reset value, so its check waits three edges.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) upCnt_q <= 2'h0;
    else if (upCnt_q != 2'h3) upCnt_q <= upCnt_q + 2'h1;
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  rd_idle_a: assert property (!$past(busReq.rd) |-> rdData == 8'h00)
    else $error("read data outside its slot");
  clr_reads_a: assert property ($past(busReq.rd) && $past(busReq.addr) >= SMI_CLR_OFS
    && $past(busReq.addr) < SMI_EN_OFS |-> rdData == 8'h00) else $error("clear reg read");
  rsvd_bits_a: assert property ($past(busReq.rd) && $past(busReq.addr) == DATA_D_OFS
    |-> rdData[7:4] == 4'h0) else $error("reserved bits set");
  pad_cause_a: assert property (pinOe != $past(pinOe) |-> $past(busReq.wr)
    || $past(busReq.wr, 2) || $past(altOe) != $past(altOe, 2)
    || $past(altOut) != $past(altOut, 2)) else $error("pad enable moved alone");
  alt_cause_a: assert property (upCnt_q == 2'h3 && altIn != $past(altIn)
    |-> $past(pinIn) != $past(pinIn, 2) || $past(busReq.wr) || $past(busReq.wr, 2))
    else $error("alternate input moved alone");
  pme_rise_a: assert property ($rose(pme) |-> $past(busReq.wr) || $past(busReq.wr, 2)
    || $past(pinIn, 2) != $past(pinIn, 3) || $past(pinIn, 3) != $past(pinIn, 4))
    else $error("wake rose alone");
  pme_fall_a: assert property ($fell(pme) |-> $past(busReq.wr) || $past(busReq.wr, 2))
    else $error("wake fell alone");
  smi_fall_a: assert property ($fell(smiIrq) |-> $past(busReq.wr)
    || $past(busReq.wr, 2)) else $error("interrupt fell alone");
endmodule
bind gpio_port_with_wake_status gpio_port_chk chk (.core_clk, .reset, .busReq, .rdData,
  .pinIn, .pinOut, .pinOe, .altOut, .altOe, .altIn, .pme, .smiIrq);
`default_nettype wire

// ---- verification/pin_world.sv ----
// Outside circuit on the general purpose pins, one wire each.
// Assumes board pull-ups on every pin and that the port wins a drive clash.
`timescale 1ns/1ns
`default_nettype none
module pin_world
  import gpio_port_pkg::*;
(
  input wire logic [NUM_PINS-1:0] pinOut, // Port drive.
  input wire logic [NUM_PINS-1:0] pinOe, // Port enable.
  input wire logic [NUM_PINS-1:0] extVal, // Outside level.
  input wire logic [NUM_PINS-1:0] extOe, // Outside drives.
  output logic [NUM_PINS-1:0] pinIn // Wire level.
);
  assign pinIn = (pinOe & pinOut) | (~pinOe & ((extOe & extVal) | ~extOe));
endmodule
`default_nettype wire

// ---- verification/gpio_port_with_wake_status_test.sv ----
// Bench for the GPIO port: register reads, pad drive, wake and interrupt events.
// Assumes the pin model resolves each wire; reads are checked from a queue.
`timescale 1ns/1ns
`default_nettype none
module gpio_port_with_wake_status_test
  import gpio_port_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  regReq_t busReq = '0;
  logic [7:0] rdData;
  logic [NUM_PINS-1:0] pinIn, pinOut, pinOe, altIn, extVal;
  logic [NUM_PINS-1:0] altOut = '0;
  logic [NUM_PINS-1:0] altOe = '0;
  logic [NUM_PINS-1:0] extOe = '1;
  logic pme, smiIrq;
  logic rdSeen = 1'b0;
  logic [7:0] expQ[$];
  int errors = 0;
  int num_checks = 0;
  int seed = 16949;
  always #25 core_clk = ~core_clk;
  gpio_port_with_wake_status DUT (.core_clk, .reset, .busReq, .rdData, .pinIn, .pinOut,
    .pinOe, .altOut, .altOe, .altIn, .pme, .smiIrq);
  pin_world world (.pinOut, .pinOe, .extVal, .extOe, .pinIn);
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
    busReq <= '{a, d, w, ~w};
    @(posedge core_clk);
    busReq <= '0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    bus(a, 8'h00, 1'b0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Released pins show no drive level, so only the enable is compared there.
  task automatic pin(input int i, input logic oe, input logic out);
    @(negedge core_clk);
    chk("pinOe", pinOe[i], oe);
    if (oe) chk("pinOut", pinOut[i], out);
    @(posedge core_clk);
  endtask
  task automatic irqs(input logic p, input logic s);
    @(negedge core_clk);
    chk("pme", pme, p);
    chk("smiIrq", smiIrq, s);
    @(posedge core_clk);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk) rdSeen <= busReq.rd;
  always @(negedge core_clk) begin
    if (rdSeen) chk("rdData", rdData, expQ.pop_front());
  end
  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
  initial begin
    extVal = NUM_PINS'($random(seed));
    tick(12);
    reset <= 1'b0;
    tick(1);
    for (int i = 0; i < NUM_PINS; i++) rd(CFG_BASE_OFS + 8'(i), CFG_RESET);
    rd(DATA_C_OFS, extVal[7:0]);
    rd(DATA_D_OFS, {4'h0, extVal[11:8]});
    rd(DATA_E_OFS, extVal[19:12]);
    rd(DATA_F_OFS, {6'h00, extVal[21:20]});
    rd(8'h00, 8'h00);
    extVal[0] <= 1'b0;
    wr(CFG_BASE_OFS, 8'h00);
    wr(DATA_C_OFS, 8'h01);
    pin(0, 1'b1, 1'b1);
    wr(CFG_BASE_OFS, 8'h02);
    pin(0, 1'b1, 1'b0);
    wr(CFG_BASE_OFS, 8'h80);
    pin(0, 1'b0, 1'b0);
    rd(DATA_C_OFS, {extVal[7:1], 1'b1});
    wr(DATA_C_OFS, {~extVal[7:1], 1'b0});
    pin(0, 1'b1, 1'b0);
    pin(1, 1'b0, 1'b0);
    wr(CFG_BASE_OFS + 8'h01, 8'h03);
    rd(DATA_C_OFS, {extVal[7:2], ~extVal[1], 1'b0});
    extVal[12] <= 1'b0;
    tick(3);
    wr(WAKE_STS_OFS + 8'h02, 8'hFF);
    wr(SMI_CLR_OFS + 8'h02, 8'hFF);
    wr(WAKE_EN_OFS + 8'h02, 8'h01);
    wr(SMI_EN_OFS + 8'h02, 8'h01);
    extVal[12] <= 1'b1;
    tick(4);
    irqs(1'b0, 1'b1);
    rd(WAKE_STS_OFS + 8'h02, 8'h01);
    rd(SMI_STS_OFS + 8'h02, 8'h01);
    wr(GLOBAL_WAKE_OFS, 8'h01);
    irqs(1'b1, 1'b1);
    wr(WAKE_STS_OFS + 8'h02, 8'h00);
    wr(SMI_CLR_OFS + 8'h02, 8'h01);
    irqs(1'b1, 1'b0);
    rd(SMI_CLR_OFS + 8'h02, 8'h00);
    wr(WAKE_STS_OFS + 8'h02, 8'h01);
    irqs(1'b0, 1'b0);
    wr(CFG_BASE_OFS + 8'h0C, 8'h03);
    wr(SMI_EN_OFS + 8'h02, 8'h00);
    extVal[12] <= 1'b0;
    tick(4);
    irqs(1'b1, 1'b0);
    wr(WAKE_STS_OFS + 8'h02, 8'h01);
    extVal[12] <= 1'b1;
    tick(4);
    irqs(1'b0, 1'b0);
    altOe <= 22'h002800;
    altOut <= 22'h002800;
    wr(CFG_BASE_OFS + 8'h0D, 8'h04);
    pin(13, 1'b1, 1'b1);
    wr(CFG_BASE_OFS + 8'h0D, 8'h06);
    pin(13, 1'b1, 1'b0);
    wr(CFG_BASE_OFS + 8'h0B, 8'h06);
    pin(11, 1'b1, 1'b1);
    @(negedge core_clk);
    chk("altIn", {6'h00, altIn[13], altIn[11]}, 8'h03);
    @(posedge core_clk);
    wr(CFG_BASE_OFS + 8'h0B, 8'h0C);
    pin(11, 1'b0, 1'b0);
    wr(CFG_BASE_OFS + 8'h0D, 8'h86);
    pin(13, 1'b1, 1'b0);
    wr(CFG_BASE_OFS + 8'h0D, 8'h84);
    pin(13, 1'b0, 1'b0);
    wr(CFG_BASE_OFS + 8'h09, 8'h0A);
    for (int k = 0; k < 2; k++) begin
      wr(WAKE_STS_OFS + 8'h01, 8'hFF);
      extVal[9] <= ~extVal[9];
      tick(4);
      rd(WAKE_STS_OFS + 8'h01, 8'h02);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
